// file: pkg/adcc_regs.svh
// Purpose: Register offsets, field positions, reset values and timing counts
//          for the converter conversion control block.
// Assumes: Byte-wide registers on a plain strobe port.
// Notes:   Offsets are word indices on the internal register port.
//
// Operation
// - Clear go bit when a single (non-repeat) conversion finishes
// - Power down after 160 idle clocks
// - Continuous mode restarts conversions automatically
// - New result overwrites previous result
// - Interrupt pulse on each continuous result
// - Four-bit channel field selects analog input
// - Repeat bit one selects continuous mode
// - Reference output pin needs reference enabled (pin follows the refout bit alone; left to software)
// - Reference pair split across two registers
// - Go write starts with same-write configuration
// - Control 0 fields act as one write
// - Result is 13 bits sign-extended
// - Ten modes: offset, gain high, gain low
// - Calibration bytes keep value across reset
// - Mode zero calibration at fixed locations
`ifndef ADCC_REGS_SVH
`define ADCC_REGS_SVH

// ============================================================
// Register offsets
`define ADCC_OFF_CTL0      8'h00
`define ADCC_OFF_CTL1      8'h01
`define ADCC_OFF_DATAH     8'h02
`define ADCC_OFF_DATAL     8'h03
`define ADCC_OFF_STAT      8'h04
`define ADCC_OFF_CAL_LO    8'h08
`define ADCC_OFF_CAL_HI    8'h7D
`define ADCC_OFF_CAL_OFS0  8'h60
`define ADCC_OFF_CAL_GH0   8'h08
`define ADCC_OFF_CAL_GL0   8'h09

// ============================================================
// Control 0 fields
`define ADCC_CTL0_GO       7
`define ADCC_CTL0_REFOUT   6
`define ADCC_CTL0_REPEAT   5
`define ADCC_CTL0_REFLO    4
`define ADCC_CHAN_MSB      3
// Control 1 fields
`define ADCC_CTL1_REFHI    7
`define ADCC_CTL0_RST      8'h00
`define ADCC_CTL1_RST      8'h80

// ============================================================
// Timing
`define ADCC_IDLE_CLKS     8'hA0
`define ADCC_CONV_TIME_NS  5100
`define ADCC_CLK_NS        100
`define ADCC_CONV_CLKS     ((`ADCC_CONV_TIME_NS + `ADCC_CLK_NS - 1) / `ADCC_CLK_NS)

`endif

// file: pkg/adcc_pkg.sv
// Purpose: Types for the converter conversion control block.
// Assumes: Nothing beyond the register header.
// Notes:   One-hot state codes written out.
package adcc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_DONE = 3'b100
  } adcc_state_t;
endpackage : adcc_pkg

// file: verilog/adcc_cal_store.sv
// Purpose: Calibration byte storage, not touched by reset.
// Assumes: One byte per index, written and read by index.
// Notes:   Contents survive reset by construction.
`include "adcc_regs.svh"
module adcc_cal_store (
  input  wire logic       core_clk,
  input  wire logic       wrEn,
  input  wire logic [6:0] wrIdx,
  input  wire logic [7:0] wrData,
  input  wire logic [6:0] rdIdx,
  output logic      [7:0] rdData
);
  logic [7:0] calMem [0:127];

  // No reset branch: factory values must hold across reset
  always_ff @(posedge core_clk) begin
    if (wrEn) begin
      calMem[wrIdx] <= wrData;
    end
  end

  assign rdData = calMem[rdIdx];
endmodule : adcc_cal_store

// file: verilog/adcc_conv_ctrl.sv
// Purpose: Conversion sequencing, result capture and register port.
// Assumes: Converter core signals done with a pulse of one or more cycles and result.
// Notes:   Register reads return data in the cycle after the strobe.
`include "adcc_regs.svh"
module adcc_conv_ctrl (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [7:0]  regRdata,
  output logic             convStart,
  output logic      [3:0]  inputChannelSel,
  output logic      [1:0]  referenceSel,
  output logic             referenceOutPin,
  output logic             converterPowerOn,
  output logic             resultIrq,
  input  wire logic        coreDone,
  input  wire logic [12:0] coreResult
);

  // ============================================================
  // Reset release
  logic rstSync1_q;
  logic rstSync2_q;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rstSync1_q <= 1'b0;
      rstSync2_q <= 1'b0;
    end else begin
      rstSync1_q <= 1'b1;
      rstSync2_q <= rstSync1_q;
    end
  end
  logic rstN;
  assign rstN = rstSync2_q;

  // ============================================================
  // Converter done input synchroniser
  logic doneS1_q;
  logic doneS2_q;
  logic doneS3_q;
  logic [12:0] resS1_q;
  logic [12:0] resS2_q;
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      doneS1_q <= 1'b0;
      doneS2_q <= 1'b0;
      doneS3_q <= 1'b0;
      resS1_q  <= 13'h0000;
      resS2_q  <= 13'h0000;
    end else begin
      doneS1_q <= coreDone;
      doneS2_q <= doneS1_q;
      doneS3_q <= doneS2_q;
      resS1_q  <= coreResult;
      resS2_q  <= resS1_q;
    end
  end
  // Rising edge only, so a stretched done pulse counts once
  logic convDone;
  assign convDone = doneS2_q & ~doneS3_q;

  // ============================================================
  // Control registers
  logic [7:0] ctl0_q;
  logic [7:0] ctl1_q;
  logic       ctl0Wr;
  logic       ctl1Wr;
  logic       calWr;
  logic       inCal;
  adcc_pkg::adcc_state_t state_q;

  assign ctl0Wr = regWr && (regAddr == `ADCC_OFF_CTL0);
  assign ctl1Wr = regWr && (regAddr == `ADCC_OFF_CTL1);
  assign inCal  = (regAddr >= `ADCC_OFF_CAL_LO) && (regAddr <= `ADCC_OFF_CAL_HI)
                  && (regAddr != `ADCC_OFF_STAT);
  assign calWr  = regWr && inCal;

  logic finishConv;
  assign finishConv = (state_q == adcc_pkg::ST_CONV) && convDone;

  // Go clears on completion unless repeating; a software write wins same cycle
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      ctl0_q <= `ADCC_CTL0_RST;
    end else if (ctl0Wr) begin
      ctl0_q <= regWdata;
    end else if (finishConv && !ctl0_q[`ADCC_CTL0_REPEAT]) begin
      ctl0_q[`ADCC_CTL0_GO] <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      ctl1_q <= `ADCC_CTL1_RST;
    end else if (ctl1Wr) begin
      ctl1_q <= regWdata;
    end
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      inputChannelSel <= 4'h0;
      referenceSel    <= 2'b10;
      referenceOutPin <= 1'b0;
    end else begin
      inputChannelSel <= ctl0_q[`ADCC_CHAN_MSB:0];
      referenceSel    <= {ctl1_q[`ADCC_CTL1_REFHI], ctl0_q[`ADCC_CTL0_REFLO]};
      // Pin follows the bit; keeping the reference on is left to software
      referenceOutPin <= ctl0_q[`ADCC_CTL0_REFOUT];
    end
  end

  // ============================================================
  // Conversion sequencer
  logic goWrite;
  assign goWrite = ctl0Wr && regWdata[`ADCC_CTL0_GO];

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      state_q   <= adcc_pkg::ST_IDLE;
      convStart <= 1'b0;
    end else begin
      convStart <= 1'b0;
      case (state_q)
        adcc_pkg::ST_IDLE: begin
          if (goWrite) begin
            state_q   <= adcc_pkg::ST_CONV;
            convStart <= 1'b1;
          end
        end
        adcc_pkg::ST_CONV: begin
          if (convDone) begin
            state_q <= adcc_pkg::ST_DONE;
          end
        end
        adcc_pkg::ST_DONE: begin
          if (ctl0_q[`ADCC_CTL0_REPEAT] && ctl0_q[`ADCC_CTL0_GO]) begin
            state_q   <= adcc_pkg::ST_CONV;
            convStart <= 1'b1;
          end else begin
            state_q <= adcc_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q <= adcc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ============================================================
  // Result capture and interrupt
  logic [12:0] result_q;
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      result_q <= 13'h0000;
    end else if (finishConv) begin
      result_q <= resS2_q;
    end
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      resultIrq <= 1'b0;
    end else begin
      resultIrq <= finishConv && ctl0_q[`ADCC_CTL0_REPEAT];
    end
  end

  // ============================================================
  // Idle power-down
  logic [7:0] idleCnt_q;
  logic       busy;
  assign busy = (state_q != adcc_pkg::ST_IDLE) || goWrite;

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      idleCnt_q        <= 8'h00;
      converterPowerOn <= 1'b0;
    end else if (busy) begin
      idleCnt_q        <= 8'h00;
      converterPowerOn <= 1'b1;
    end else if (idleCnt_q == (`ADCC_IDLE_CLKS - 8'h01)) begin
      converterPowerOn <= 1'b0;
    end else begin
      idleCnt_q <= idleCnt_q + 8'h01;
    end
  end

  // ============================================================
  // Calibration store
  logic [7:0] calRd;
  adcc_cal_store uCal (
    .core_clk (core_clk),
    .wrEn     (calWr),
    .wrIdx    (regAddr[6:0]),
    .wrData   (regWdata),
    .rdIdx    (regAddr[6:0]),
    .rdData   (calRd)
  );

  // ============================================================
  // Read port: data the cycle after the strobe, else zero
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      regRdata <= 8'h00;
    end else if (regRd) begin
      case (regAddr)
        `ADCC_OFF_CTL0:  regRdata <= ctl0_q;
        `ADCC_OFF_CTL1:  regRdata <= ctl1_q;
        `ADCC_OFF_DATAH: regRdata <= {{3{result_q[12]}}, result_q[12:8]};
        `ADCC_OFF_DATAL: regRdata <= result_q[7:0];
        `ADCC_OFF_STAT:  regRdata <= {5'h00, state_q};
        default:         regRdata <= inCal ? calRd : 8'h00;
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end

  // ============================================================
  // Checks: go bit and sequencing
  a_go_clears: assert property (@(posedge core_clk) disable iff (!rstN)
    finishConv && !ctl0_q[`ADCC_CTL0_REPEAT] && !ctl0Wr |=> !ctl0_q[`ADCC_CTL0_GO])
    else $error("go bit not cleared");

  a_repeat_keep: assert property (@(posedge core_clk) disable iff (!rstN)
    finishConv && ctl0_q[`ADCC_CTL0_REPEAT] && !ctl0Wr |=> ctl0_q == $past(ctl0_q))
    else $error("repeat go lost");

  a_repeat_mode_sel_restart: assert property (@(posedge core_clk) disable iff (!rstN)
    state_q == adcc_pkg::ST_DONE && ctl0_q[`ADCC_CTL0_REPEAT] && ctl0_q[`ADCC_CTL0_GO]
    |=> convStart) else $error("no restart");

  a_start_pulse: assert property (@(posedge core_clk) disable iff (!rstN)
    convStart |=> !convStart) else $error("start not a pulse");

  a_go_start: assert property (@(posedge core_clk) disable iff (!rstN)
    goWrite && state_q == adcc_pkg::ST_IDLE |=> convStart) else $error("no start");

  a_stop_idle: assert property (@(posedge core_clk) disable iff (!rstN)
    state_q == adcc_pkg::ST_DONE && !ctl0_q[`ADCC_CTL0_GO]
    |=> state_q == adcc_pkg::ST_IDLE) else $error("no stop");

  a_state_onehot: assert property (@(posedge core_clk) disable iff (!rstN)
    $onehot(state_q)) else $error("state not one-hot");

  // ============================================================
  // Checks: results and interrupt
  a_res_update: assert property (@(posedge core_clk) disable iff (!rstN)
    finishConv |=> result_q == $past(resS2_q)) else $error("result stale");

  a_irq_repeat_mode_sel: assert property (@(posedge core_clk) disable iff (!rstN)
    finishConv && ctl0_q[`ADCC_CTL0_REPEAT] |=> resultIrq) else $error("no irq");

  a_irq_single: assert property (@(posedge core_clk) disable iff (!rstN)
    finishConv && !ctl0_q[`ADCC_CTL0_REPEAT] |=> !resultIrq)
    else $error("irq in single mode");

  a_data_sign: assert property (@(posedge core_clk) disable iff (!rstN)
    regRd && regAddr == `ADCC_OFF_DATAH
    |=> regRdata == {{3{$past(result_q[12])}}, $past(result_q[12:8])})
    else $error("high byte not sign extended");

  a_rd_idle: assert property (@(posedge core_clk) disable iff (!rstN)
    !regRd |=> regRdata == 8'h00) else $error("read data outside slot");

  // ============================================================
  // Checks: configuration fields
  a_ctl0_write: assert property (@(posedge core_clk) disable iff (!rstN)
    ctl0Wr |=> ctl0_q == $past(regWdata)) else $error("ctl0 write lost");

  a_chan_sel: assert property (@(posedge core_clk) disable iff (!rstN)
    ctl0Wr ##1 !ctl0Wr |=> inputChannelSel == $past(ctl0_q[3:0]))
    else $error("bad channel");

  a_ref_pair: assert property (@(posedge core_clk) disable iff (!rstN)
    1'b1 |=> referenceSel == $past({ctl1_q[7], ctl0_q[4]})) else $error("ref pair");

  a_ref_out: assert property (@(posedge core_clk) disable iff (!rstN)
    1'b1 |=> referenceOutPin == $past(ctl0_q[`ADCC_CTL0_REFOUT]))
    else $error("ref out pin");

  // ============================================================
  // Checks: idle power-down
  a_idle_pdown: assert property (@(posedge core_clk) disable iff (!rstN)
    !busy && idleCnt_q == 8'h9F |=> !converterPowerOn)
    else $error("no power down");

  a_power_on: assert property (@(posedge core_clk) disable iff (!rstN)
    goWrite |=> converterPowerOn) else $error("no power up");

  a_idle_clear: assert property (@(posedge core_clk) disable iff (!rstN)
    busy |=> idleCnt_q == 8'h00) else $error("idle count kept");

  // Main scenarios
  c_single: cover property (@(posedge core_clk) finishConv && !ctl0_q[`ADCC_CTL0_REPEAT]);
  c_repeat_mode_sel: cover property (@(posedge core_clk) resultIrq);
  c_pdown: cover property (@(posedge core_clk) $fell(converterPowerOn));
  c_stop: cover property (@(posedge core_clk)
    state_q == adcc_pkg::ST_DONE && !ctl0_q[`ADCC_CTL0_GO] && ctl0_q[`ADCC_CTL0_REPEAT]);
endmodule : adcc_conv_ctrl

// file: test/adcc_core_model.sv
// Purpose: Behavioural converter core answering start pulses.
// Assumes: Start is a one-cycle pulse; delay and result come from the bench.
// Notes:   Result lines carry the inverse whenever done is low.
module adcc_core_model (
  input  wire logic        core_clk,
  input  wire logic        convStart,
  input  wire logic [7:0]  convDelay,
  input  wire logic [12:0] resVal,
  output logic             coreDone,
  output logic      [12:0] coreResult
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] cnt_q = 9'h000;
  initial coreDone = 1'b0;
  // ============================================================
  // Done held three cycles so the two-flop sync surely sees it
  always @(posedge core_clk) begin
    if (convStart) cnt_q <= {1'b0, convDelay} + 9'h003;
    else if (cnt_q != 9'h000) cnt_q <= cnt_q - 9'h001;
    coreDone <= (cnt_q != 9'h000) && (cnt_q <= 9'h003) && !convStart;
  end
  assign coreResult = coreDone ? resVal : ~resVal;
endmodule : adcc_core_model

// file: test/tb_adc_conversion_control.sv
// Purpose: Self-checking bench for the conversion control block.
// Assumes: Register reads answer one cycle after the strobe.
// Notes:   Random values from a fixed-seed xorshift.
module tb_adc_conversion_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk = 0, nrst = 0, regWr = 0, regRd = 0, coreDone, convStart;
  logic [7:0]  regAddr = 0, regWdata = 0, regRdata, convDelay = 8'h05, d, ctl, cfg;
  logic [7:0]  calO, calGh, calGl;
  logic [3:0]  inputChannelSel;
  logic [1:0]  referenceSel;
  logic        referenceOutPin, converterPowerOn, resultIrq;
  logic [12:0] coreResult, resVal = 0;
  logic [31:0] seed = 32'h0eca_7aaf;
  int          num_errors = 0, checks_done = 0, cycles = 0, irqCnt = 0, startCnt = 0, s, t;

  adcc_conv_ctrl uut (.core_clk(core_clk), .nrst(nrst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .convStart(convStart), .inputChannelSel(inputChannelSel),
    .referenceSel(referenceSel), .referenceOutPin(referenceOutPin),
    .converterPowerOn(converterPowerOn), .resultIrq(resultIrq),
    .coreDone(coreDone), .coreResult(coreResult));
  adcc_core_model core (.core_clk(core_clk), .convStart(convStart),
    .convDelay(convDelay), .resVal(resVal), .coreDone(coreDone), .coreResult(coreResult));

  always #50 core_clk = ~core_clk;
  // ============================================================
  // Event counters and hang guard
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (resultIrq === 1'b1) irqCnt <= irqCnt + 1;
    if (convStart === 1'b1) startCnt <= startCnt + 1;
    if (cycles == 30000) begin
      num_errors++;
      stop_test();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs
  function automatic logic [7:0] hiByte(input logic [12:0] r);
    return {{3{r[12]}}, r[12:8]};
  endfunction : hiByte
  // Software correction: offset first, then gain over two to the sixteenth
  function automatic logic [15:0] comp(input logic [12:0] r, input logic [7:0] o,
                                       input logic [15:0] g);
    logic signed [39:0] x;
    x = $signed({{27{r[12]}}, r}) - $signed({{32{o[7]}}, o});
    x = x + ((x * $signed({24'h00_0000, g})) >>> 16);
    return x[15:0];
  endfunction : comp
  function automatic logic [15:0] scale87(input logic [12:0] r);
    logic signed [31:0] x;
    x = $signed({{19{r[12]}}, r});
    x = (x * 8) / 7;
    return x[15:0];
  endfunction : scale87

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    regAddr <= a; regWdata <= v; regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk);
    regAddr <= a; regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 v = regRdata;
  endtask : rd
  task automatic result();
    rd(8'h03, d); chk("dataLow", resVal[7:0], d);
    rd(8'h02, d); chk("dataHigh", hiByte(resVal), d);
  endtask : result
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  initial begin
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge core_clk);
    rd(8'h01, d); chk("ctl1Reset", 8'h80, d);
    rd(8'h00, d); chk("ctl0Reset", 8'h00, d);
    rd(8'h05, d); chk("unmapped", 8'h00, d);
    chk("refSelReset", 2'b10, referenceSel);
    chk("powerReset", 1'b0, converterPowerOn);
    $display("reset test done");
    // Single shots over every reference combination, fast and slow core
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      resVal <= seed[12:0];
      convDelay <= (i == 3) ? 8'h3c : {3'h0, seed[20:16]};
      cfg = {1'b0, i[0], 1'b0, i[1], seed[27:24]};
      wr(8'h01, {~i[0], 7'h00});
      wr(8'h00, cfg | 8'h80);
      repeat (3) @(posedge core_clk);
      chk("channel", cfg[3:0], inputChannelSel);
      chk("refSel", {~i[0], i[1]}, referenceSel);
      chk("refOut", i[0], referenceOutPin);
      chk("powerOn", 1'b1, converterPowerOn);
      s = irqCnt;
      for (t = 0; t < 200; t++) begin
        rd(8'h00, ctl);
        if (ctl[7] === 1'b0) break;
      end
      chk("goCleared", cfg, ctl);
      result();
      chk("singleNoIrq", s, irqCnt);
    end
    repeat (120) @(posedge core_clk);
    chk("powerHeld", 1'b1, converterPowerOn);
    repeat (60) @(posedge core_clk);
    chk("powerDown", 1'b0, converterPowerOn);
    $display("single test done");
    // Continuous run, results overwritten each time
    convDelay <= 8'h0c;
    wr(8'h00, 8'ha5);
    for (int k = 0; k < 4; k++) begin
      s = irqCnt;
      for (t = 0; t < 500 && irqCnt == s; t++) @(posedge core_clk);
      chk("irqSeen", 1'b1, irqCnt != s);
      result();
      rd(8'h00, d); chk("goKept", 8'ha5, d);
      seed = xs(seed);
      resVal <= seed[12:0];
    end
    wr(8'h00, 8'h25);
    repeat (300) @(posedge core_clk);
    // Four single shots started without an interrupt
    chk("startsPaired", irqCnt + 4, startCnt);
    s = startCnt;
    repeat (50) @(posedge core_clk);
    chk("stopped", s, startCnt);
    $display("continuous test done");
    // Calibration bytes survive a reset applied after conversions have stopped
    wr(8'h60, seed[7:0]);
    wr(8'h08, seed[15:8]);
    wr(8'h09, seed[23:16]);
    nrst <= 1'b0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge core_clk);
    rd(8'h60, calO); chk("calOffset", seed[7:0], calO);
    rd(8'h08, calGh); chk("calGainHigh", seed[15:8], calGh);
    rd(8'h09, calGl); chk("calGainLow", seed[23:16], calGl);
    rd(8'h02, ctl); rd(8'h03, cfg);
    chk("compensated", comp(13'h0000, seed[7:0], seed[15:0] & 16'h0000 | {seed[15:8], seed[23:16]}), comp({ctl[4:0], cfg}, calO, {calGh, calGl}));
    chk("scaled", 16'h0000, scale87({ctl[4:0], cfg}));
    $display("calibration test done");
    stop_test();
  end
endmodule : tb_adc_conversion_control
